// ---- logic/gpcfg_port.sv ----
/*
 * GPIO port configuration bank: selector register plus indirectly
 * reached sub-registers, pad steering and stop-mode wake request.
 * Assumes a one-cycle read or write strobe from the core, one clock.
 */
`timescale 1ns/1ps
module gpcfg_port
    import gpcfg_pkg::*;
#(
    parameter bit SMALL_PORT = 1'b0
)(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       sel_wr_i,
    input  wire logic       win_wr_i,
    input  wire logic       win_rd_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [7:0] alt_function_enable_i,
    input  wire logic [7:0] af_data_i,
    input  wire logic [7:0] af_oe_i,
    input  wire logic [7:0] gp_data_i,
    input  wire logic [7:0] gp_oe_i,
    input  wire logic [7:0] pin_i,
    input  wire logic       stop_mode_i,
    output logic      [7:0] port_selector_o,
    output logic      [7:0] rdata_o,
    output logic      [7:0] pad_out_o,
    output logic      [7:0] pad_oe_o,
    output logic      [7:0] high_current_bits_o,
    output logic      [7:0] pullup_bits_o,
    output logic      [7:0] alt_select_a_bits_o,
    output logic      [7:0] alt_select_b_bits_o,
    output logic            stop_recover_o
);
    localparam logic [7:0] RST_ALT = SMALL_PORT ? RST_ALT_SMALL : RST_ZERO;

    logic [7:0] sel_ff;
    logic [7:0] od_ff;
    logic [7:0] hd_ff;
    logic [7:0] wake_ff;
    logic [7:0] pu_ff;
    logic [7:0] alta_ff;
    logic [7:0] altb_ff;
    logic [7:0] rdata_ff;
    logic [7:0] pad_out_ff;
    logic [7:0] pad_oe_ff;
    logic [7:0] hd_out_ff;
    logic [7:0] pu_out_ff;
    logic [7:0] alta_out_ff;
    logic [7:0] altb_out_ff;
    logic       recover_ff;
    logic [7:0] nxt_pad_out;
    logic [7:0] nxt_pad_oe;
    logic       nxt_recover;
    logic [7:0] nxt_rdata;
    gpcfg_sub_e sub;

    assign sub = gpcfg_decode(sel_ff);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sel_ff <= RST_SELECTOR;
        end else if (sel_wr_i) begin
            sel_ff <= wdata_i;
        end
    end

    // Selector 00H and unmapped codes swallow writes by design
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            od_ff   <= RST_ZERO;
            hd_ff   <= RST_ZERO;
            wake_ff <= RST_ZERO;
            pu_ff   <= RST_ZERO;
            alta_ff <= RST_ALT;
            altb_ff <= RST_ALT;
        end else if (win_wr_i) begin
            case (sub)
                SUB_OD:   od_ff   <= wdata_i;
                SUB_HD:   hd_ff   <= wdata_i;
                SUB_WAKE: wake_ff <= wdata_i;
                SUB_PU:   pu_ff   <= wdata_i;
                SUB_ALTA: alta_ff <= wdata_i;
                SUB_ALTB: altb_ff <= wdata_i;
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (sub)
            SUB_OD:   nxt_rdata = od_ff;
            SUB_HD:   nxt_rdata = hd_ff;
            SUB_WAKE: nxt_rdata = wake_ff;
            SUB_PU:   nxt_rdata = pu_ff;
            SUB_ALTA: nxt_rdata = alta_ff;
            SUB_ALTB: nxt_rdata = altb_ff;
            default:  nxt_rdata = RST_ZERO;
        endcase
    end

    // Read data lands one cycle after the strobe and holds
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_ff <= RST_ZERO;
        end else if (win_rd_i) begin
            rdata_ff <= nxt_rdata;
        end
    end

    gpcfg_pad_ctl u_pad (
        .af_en_i           (alt_function_enable_i),
        .af_data_i         (af_data_i),
        .af_oe_i           (af_oe_i),
        .gp_data_i         (gp_data_i),
        .gp_oe_i           (gp_oe_i),
        .open_drain_bits_i (od_ff),
        .pad_out_o         (nxt_pad_out),
        .pad_oe_o          (nxt_pad_oe)
    );

    gpcfg_wake_det u_wake (
        .sys_clk_i          (sys_clk_i),
        .rst_i              (rst_i),
        .pin_i              (pin_i),
        .wake_source_bits_i (wake_ff),
        .stop_mode_i        (stop_mode_i),
        .wake_hit_o         (nxt_recover)
    );

    // Registered pad controls cost one cycle of latency
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pad_out_ff <= RST_ZERO;
            pad_oe_ff  <= RST_ZERO;
        end else begin
            pad_out_ff <= nxt_pad_out;
            pad_oe_ff  <= nxt_pad_oe;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            hd_out_ff   <= RST_ZERO;
            pu_out_ff   <= RST_ZERO;
            alta_out_ff <= RST_ZERO;
            altb_out_ff <= RST_ZERO;
        end else begin
            hd_out_ff   <= hd_ff;
            pu_out_ff   <= pu_ff;
            alta_out_ff <= alta_ff & alt_function_enable_i;
            altb_out_ff <= altb_ff & alt_function_enable_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            recover_ff <= 1'b0;
        end else begin
            recover_ff <= nxt_recover;
        end
    end

    assign port_selector_o     = sel_ff;
    assign rdata_o             = rdata_ff;
    assign pad_out_o           = pad_out_ff;
    assign pad_oe_o            = pad_oe_ff;
    assign high_current_bits_o = hd_out_ff;
    assign pullup_bits_o       = pu_out_ff;
    assign alt_select_a_bits_o = alta_out_ff;
    assign alt_select_b_bits_o = altb_out_ff;
    assign stop_recover_o      = recover_ff;

    property p_od_write;
        @(posedge sys_clk_i) disable iff (rst_i)
        (win_wr_i && sel_ff == SEL_OPEN_DRAIN) |=> od_ff == $past(wdata_i);
    endproperty
    a_od_write: assert property (p_od_write)
        else $error("open-drain write lost");

    property p_hd_write;
        @(posedge sys_clk_i) disable iff (rst_i)
        (win_wr_i && sel_ff == SEL_HIGH_DRIVE) |=> ##1
            high_current_bits_o == $past(wdata_i, 2);
    endproperty
    a_hd_write: assert property (p_hd_write)
        else $error("high drive not applied");

    property p_pu_write;
        @(posedge sys_clk_i) disable iff (rst_i)
        (win_wr_i && sel_ff == SEL_PULLUP) |=> ##1
            pullup_bits_o == $past(wdata_i, 2);
    endproperty
    a_pu_write: assert property (p_pu_write)
        else $error("pull-up not applied");

    property p_readback;
        @(posedge sys_clk_i) disable iff (rst_i)
        (win_rd_i && sel_ff == SEL_ALT_B) |=> rdata_o == $past(altb_ff);
    endproperty
    a_readback: assert property (p_readback)
        else $error("readback mismatch");

    property p_unmapped_read;
        @(posedge sys_clk_i) disable iff (rst_i)
        (win_rd_i && sel_ff == RST_SELECTOR) |=> rdata_o == RST_ZERO;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not zero");

    property p_od_no_high;
        @(posedge sys_clk_i) disable iff (rst_i)
        $past(od_ff[0] && nxt_pad_out[0]) |-> !pad_oe_o[0];
    endproperty
    a_od_no_high: assert property (p_od_no_high)
        else $error("open drain drove high");

    property p_alt_gate;
        @(posedge sys_clk_i) disable iff (rst_i)
        !alt_function_enable_i[0] |=> !alt_select_a_bits_o[0];
    endproperty
    a_alt_gate: assert property (p_alt_gate)
        else $error("alt select leaked");

    sequence s_wake_edge;
        stop_mode_i && wake_ff[1] && $changed(pin_i[1]);
    endsequence
    property p_wake;
        @(posedge sys_clk_i) disable iff (rst_i)
        s_wake_edge |-> ##1 stop_recover_o;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake edge missed");

    property p_no_wake;
        @(posedge sys_clk_i) disable iff (rst_i)
        !stop_mode_i |=> !stop_recover_o;
    endproperty
    a_no_wake: assert property (p_no_wake)
        else $error("wake outside stop");

    property p_sel_write;
        @(posedge sys_clk_i) disable iff (rst_i)
        sel_wr_i |=> port_selector_o == $past(wdata_i);
    endproperty
    a_sel_write: assert property (p_sel_write)
        else $error("selector write lost");

    property p_wake_write;
        @(posedge sys_clk_i) disable iff (rst_i)
        (win_wr_i && sel_ff == SEL_WAKE_SRC) |=> wake_ff == $past(wdata_i);
    endproperty
    a_wake_write: assert property (p_wake_write)
        else $error("wake source write lost");

    property p_alta_write;
        @(posedge sys_clk_i) disable iff (rst_i)
        (win_wr_i && sel_ff == SEL_ALT_A) |=> alta_ff == $past(wdata_i);
    endproperty
    a_alta_write: assert property (p_alta_write)
        else $error("alternate select a write lost");

    property p_altb_write;
        @(posedge sys_clk_i) disable iff (rst_i)
        (win_wr_i && sel_ff == SEL_ALT_B) |=> altb_ff == $past(wdata_i);
    endproperty
    a_altb_write: assert property (p_altb_write)
        else $error("alternate select b write lost");

    property p_od_read;
        @(posedge sys_clk_i) disable iff (rst_i)
        (win_rd_i && sel_ff == SEL_OPEN_DRAIN) |=> rdata_o == $past(od_ff);
    endproperty
    a_od_read: assert property (p_od_read)
        else $error("open-drain readback mismatch");

    property p_od_drive;
        @(posedge sys_clk_i) disable iff (rst_i)
        $past(!od_ff[1] && !alt_function_enable_i[1]) |->
            pad_oe_o[1] == $past(gp_oe_i[1]);
    endproperty
    a_od_drive: assert property (p_od_drive)
        else $error("push-pull drive lost");

    property p_af_route;
        @(posedge sys_clk_i) disable iff (rst_i)
        $past(alt_function_enable_i[0]) |->
            pad_out_o[0] == $past(af_data_i[0]);
    endproperty
    a_af_route: assert property (p_af_route)
        else $error("alternate data not routed");

    property p_alt_gate_b;
        @(posedge sys_clk_i) disable iff (rst_i)
        !alt_function_enable_i[1] |=> !alt_select_b_bits_o[1];
    endproperty
    a_alt_gate_b: assert property (p_alt_gate_b)
        else $error("alt select b leaked");
endmodule

// ---- common/gpcfg_pkg.sv ----
/*
 * Constants for the GPIO port configuration sub-register bank.
 * Assumes an 8-bit register port and one system clock.
 */
package gpcfg_pkg;
    localparam int unsigned GPCFG_W = 8;
    localparam logic [7:0] SEL_OPEN_DRAIN = 8'h03;
    localparam logic [7:0] SEL_HIGH_DRIVE = 8'h04;
    localparam logic [7:0] SEL_WAKE_SRC   = 8'h05;
    localparam logic [7:0] SEL_PULLUP     = 8'h06;
    localparam logic [7:0] SEL_ALT_A      = 8'h07;
    localparam logic [7:0] SEL_ALT_B      = 8'h08;
    localparam logic [7:0] RST_ZERO       = 8'h00;
    localparam logic [7:0] RST_ALT_SMALL  = 8'h04;
    localparam logic [7:0] RST_SELECTOR   = 8'h00;

    typedef enum logic [2:0] {
        SUB_NONE,
        SUB_OD,
        SUB_HD,
        SUB_WAKE,
        SUB_PU,
        SUB_ALTA,
        SUB_ALTB
    } gpcfg_sub_e;

    function automatic gpcfg_sub_e gpcfg_decode(input logic [7:0] sel);
        case (sel)
            SEL_OPEN_DRAIN: gpcfg_decode = SUB_OD;
            SEL_HIGH_DRIVE: gpcfg_decode = SUB_HD;
            SEL_WAKE_SRC:   gpcfg_decode = SUB_WAKE;
            SEL_PULLUP:     gpcfg_decode = SUB_PU;
            SEL_ALT_A:      gpcfg_decode = SUB_ALTA;
            SEL_ALT_B:      gpcfg_decode = SUB_ALTB;
            default:        gpcfg_decode = SUB_NONE;
        endcase
    endfunction
endpackage

// ---- logic/gpcfg_pad_ctl.sv ----
/*
 * Per-pin pad steering from the configuration bits.
 * Assumes the alternate function supplies its own data and drive enable.
 */
`timescale 1ns/1ps
module gpcfg_pad_ctl
    import gpcfg_pkg::*;
(
    input  wire logic [7:0] af_en_i,
    input  wire logic [7:0] af_data_i,
    input  wire logic [7:0] af_oe_i,
    input  wire logic [7:0] gp_data_i,
    input  wire logic [7:0] gp_oe_i,
    input  wire logic [7:0] open_drain_bits_i,
    output logic      [7:0] pad_out_o,
    output logic      [7:0] pad_oe_o
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad_out_o[i] = af_en_i[i] ? af_data_i[i] : gp_data_i[i];
            pad_oe_o[i]  = af_en_i[i] ? af_oe_i[i] : gp_oe_i[i];
            // Open drain on: a one floats, only the low side drives
            if (open_drain_bits_i[i] && pad_out_o[i]) begin
                pad_oe_o[i] = 1'b0;
            end
        end
    end
endmodule

// ---- logic/gpcfg_wake_det.sv ----
/*
 * Stop-mode wake detector over one port.
 * Assumes pin levels already synchronous to the clock.
 */
`timescale 1ns/1ps
module gpcfg_wake_det
    import gpcfg_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] pin_i,
    input  wire logic [7:0] wake_source_bits_i,
    input  wire logic       stop_mode_i,
    output logic            wake_hit_o
);
    logic [7:0] prev_ff;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            // Track pins through reset so release shows no false edge
            prev_ff <= pin_i;
        end else begin
            prev_ff <= pin_i;
        end
    end
    assign wake_hit_o = stop_mode_i
        && |((prev_ff ^ pin_i) & wake_source_bits_i);
endmodule

// ---- sim/tb_gpcfg_port.sv ----
/*
 * Self-checking bench for the GPIO configuration sub-register bank.
 * Assumes gpcfg_pkg is compiled first; the bench drives every port.
 */
`timescale 1ns/1ps
module tb_gpcfg_port
    import gpcfg_pkg::*;
;
    logic       sys_clk_i = 1'b0;
    logic       rst_i     = 1'b1;
    logic       sel_wr_i  = 1'b0;
    logic       win_wr_i  = 1'b0;
    logic       win_rd_i  = 1'b0;
    logic       stop_mode_i = 1'b0;
    logic [7:0] wdata_i   = 8'h00;
    logic [7:0] af_en_i   = 8'h00;
    logic [7:0] af_data_i = 8'h00;
    logic [7:0] af_oe_i   = 8'h00;
    logic [7:0] gp_data_i = 8'h00;
    logic [7:0] gp_oe_i   = 8'h00;
    logic [7:0] pin_i     = 8'h00;
    logic [7:0] sel_q, rdata, pad_out, pad_oe, hc, pu, alt_a, alt_b;
    logic       recover;
    int         n_fail = 0;
    int         samples_checked = 0;
    logic [7:0] sels [6] = '{SEL_OPEN_DRAIN, SEL_HIGH_DRIVE, SEL_WAKE_SRC,
                             SEL_PULLUP, SEL_ALT_A, SEL_ALT_B};
    logic [7:0] expv [6] = '{6{8'h00}};
    logic [7:0] expv_s [6] = '{8'h00, 8'h00, 8'h00, 8'h00,
                               RST_ALT_SMALL, RST_ALT_SMALL};
    logic [7:0] rdata_s;
    logic [7:0] bad  [5] = '{8'h00, 8'h01, 8'h02, 8'h09, 8'hFF};

    always #25 sys_clk_i = ~sys_clk_i;

    gpcfg_port #(.SMALL_PORT(1'b0)) u_dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sel_wr_i(sel_wr_i),
        .win_wr_i(win_wr_i), .win_rd_i(win_rd_i), .wdata_i(wdata_i),
        .alt_function_enable_i(af_en_i), .af_data_i(af_data_i),
        .af_oe_i(af_oe_i), .gp_data_i(gp_data_i), .gp_oe_i(gp_oe_i),
        .pin_i(pin_i), .stop_mode_i(stop_mode_i), .port_selector_o(sel_q),
        .rdata_o(rdata), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
        .high_current_bits_o(hc), .pullup_bits_o(pu),
        .alt_select_a_bits_o(alt_a), .alt_select_b_bits_o(alt_b),
        .stop_recover_o(recover));

    // Small-port copy shares every input; only its readback is judged
    gpcfg_port #(.SMALL_PORT(1'b1)) u_dut_small (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sel_wr_i(sel_wr_i),
        .win_wr_i(win_wr_i), .win_rd_i(win_rd_i), .wdata_i(wdata_i),
        .alt_function_enable_i(af_en_i), .af_data_i(af_data_i),
        .af_oe_i(af_oe_i), .gp_data_i(gp_data_i), .gp_oe_i(gp_oe_i),
        .pin_i(pin_i), .stop_mode_i(stop_mode_i), .port_selector_o(),
        .rdata_o(rdata_s), .pad_out_o(), .pad_oe_o(),
        .high_current_bits_o(), .pullup_bits_o(),
        .alt_select_a_bits_o(), .alt_select_b_bits_o(),
        .stop_recover_o());

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, seen);
            n_fail++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    // Strobes last exactly one edge, as the core issues them
    task automatic wr_sel(input logic [7:0] v);
        @(posedge sys_clk_i);
        sel_wr_i <= 1'b1;
        wdata_i  <= v;
        @(posedge sys_clk_i);
        sel_wr_i <= 1'b0;
    endtask

    task automatic wr_win(input logic [7:0] v);
        @(posedge sys_clk_i);
        win_wr_i <= 1'b1;
        wdata_i  <= v;
        @(posedge sys_clk_i);
        win_wr_i <= 1'b0;
    endtask

    task automatic rd_win(output logic [7:0] v);
        @(posedge sys_clk_i);
        win_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        win_rd_i <= 1'b0;
        #1 v = rdata;
    endtask

    // Reads every mapped sub-register back against the shadow copy
    task automatic check_all();
        logic [7:0] v;
        for (int i = 0; i < 6; i++) begin
            wr_sel(sels[i]);
            rd_win(v);
            chk("port_selector", sel_q, sels[i]);
            chk("subreg read", v, expv[i]);
            chk("small subreg read", rdata_s, expv_s[i]);
        end
    endtask

    task automatic t_regs();
        logic [7:0] v;
        check_all();
        for (int i = 0; i < 6; i++) begin
            expv[i] = 8'(8'h11 * (i + 1));
            expv_s[i] = expv[i];
            wr_sel(sels[i]);
            wr_win(expv[i]);
        end
        check_all();
        // Unmapped codes must neither store nor disturb neighbours
        foreach (bad[i]) begin
            wr_sel(bad[i]);
            wr_win(8'hFF);
            rd_win(v);
            chk("unmapped read", v, 8'h00);
        end
        check_all();
        $display("test regs done");
    endtask

    task automatic t_outs();
        @(posedge sys_clk_i);
        af_en_i <= 8'h0F;
        tick(2);
        chk("high_current", hc, expv[1]);
        chk("pullup", pu, expv[3]);
        chk("alt_a", alt_a, expv[4] & 8'h0F);
        chk("alt_b", alt_b, expv[5] & 8'h0F);
        $display("test outs done");
    endtask

    task automatic t_pad();
        @(posedge sys_clk_i);
        af_en_i   <= 8'h00;
        gp_data_i <= 8'hFF;
        gp_oe_i   <= 8'hFF;
        tick(2);
        chk("pad_oe od high", pad_oe, ~expv[0]);
        chk("pad_out od high", pad_out & ~expv[0], ~expv[0]);
        @(posedge sys_clk_i);
        gp_data_i <= 8'h00;
        tick(2);
        chk("pad_oe low", pad_oe, 8'hFF);
        chk("pad_out low", pad_out, 8'h00);
        @(posedge sys_clk_i);
        af_en_i   <= 8'h03;
        af_data_i <= 8'h03;
        af_oe_i   <= 8'h03;
        gp_oe_i   <= 8'h00;
        tick(2);
        chk("pad_oe alt", pad_oe, 8'h02);
        chk("pad_out alt", pad_out & 8'h02, 8'h02);
        $display("test pad done");
    endtask

    // Edge detection latency may be one or two edges; watch three
    task automatic wake_try(input logic [7:0] p, input logic s, e);
        logic seen;
        seen = 1'b0;
        @(posedge sys_clk_i);
        stop_mode_i <= s;
        @(posedge sys_clk_i);
        pin_i <= p;
        repeat (3) begin
            @(posedge sys_clk_i);
            #1 seen = seen | recover;
        end
        chk("wake", {7'h00, seen}, {7'h00, e});
    endtask

    task automatic t_wake();
        wake_try(8'h02, 1'b1, 1'b1);
        wake_try(8'h06, 1'b1, 1'b0);
        wake_try(8'h04, 1'b1, 1'b1);
        wake_try(8'h05, 1'b0, 1'b0);
        $display("test wake done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #(50 * 5000);
        n_fail++;
        end_sim();
    end

    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_outs();
        t_pad();
        t_wake();
        end_sim();
    end
endmodule
